// >>> core/lsd_core.sv
// Serial-in, latched parallel-out control logic of a 16-channel LED sink driver.
// Functional notes
// R1: Sixteen-stage shift register feeds sixteen-bit channel latch.
// R2: Rising shift clock loads input, advances every stage; a rise that finds the four-entry buffer full (shift_stall_in held) is dropped.
// R3: Strobe high passes register; strobe low holds.
// R4: Enable input high forces every channel off.
// R5: Cascade output shows the last register stage.
// R6: Controller keeps shift clock at most 25 MHz; this core needs each clock phase at least three system cycles long.
// R7: Falling shift clock changes nothing at all.
`timescale 1ns/10ps
`default_nettype none
module lsd_core
   import lsd_pkg::*;
(
   // Clock and reset
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_n_in,
   // Serial link from the display controller
   input  wire logic                    serial_data_in,
   input  wire logic                    shift_clk_in,
   input  wire logic                    latch_strobe_in,
   input  wire logic                    output_enable_n_in,
   // Stall from the downstream drain logic
   input  wire logic                    shift_stall_in,
   // Outputs
   output logic [lsd_pkg::LSD_CHANNELS-1:0] led_sink_channels_out,
   output logic                         cascade_data_out,
   output logic                         accept_ready_out
);
   import lsd_pkg::*;

   localparam int unsigned PIN_BITS = $bits(lsd_pins_t);

   // ==========================================================
   // Pin sampling: three flip-flops on every pin from the controller.
   lsd_pins_t pins_raw;
   lsd_pins_t sync1_reg;
   lsd_pins_t sync1_next;
   lsd_pins_t sync2_reg;
   lsd_pins_t sync2_next;
   lsd_pins_t sync3_reg;
   lsd_pins_t sync3_next;

   always_comb begin
      pins_raw.serial    = serial_data_in;
      pins_raw.shift_clk = shift_clk_in;
      pins_raw.strobe    = latch_strobe_in;
      pins_raw.blank     = output_enable_n_in;
      sync1_next         = pins_raw;
      sync2_next         = sync1_reg;
      sync3_next         = sync2_reg;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sync1_reg <= LSD_PIN_RST;
         sync2_reg <= LSD_PIN_RST;
         sync3_reg <= LSD_PIN_RST;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
      end
   end

   // ==========================================================
   // Agreement filter. Each pin is judged on its own, so a strobe or enable
   // change close to a shift edge cannot hold that edge back.
   lsd_pins_t filt_reg;
   lsd_pins_t filt_next;

   always_comb begin
      filt_next = filt_reg;
      for (int unsigned i = 0; i < PIN_BITS; i++) begin
         if (sync2_reg[i] == sync3_reg[i]) begin
            filt_next[i] = sync3_reg[i];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         filt_reg <= LSD_PIN_RST;
      end else begin
         filt_reg <= filt_next;
      end
   end

   // ==========================================================
   // Shift clock edge detection.
   logic sclk_prev_reg;
   logic sclk_prev_next;
   logic sclk_rise;

   always_comb begin
      sclk_prev_next = filt_reg.shift_clk;
      // Only the low-to-high change is an event; a falling edge touches nothing.
      sclk_rise      = filt_reg.shift_clk && !sclk_prev_reg; // R2 R7
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         // Same level as the filter's reset, so release makes no false edge.
         sclk_prev_reg <= 1'h0;
      end else begin
         sclk_prev_reg <= sclk_prev_next;
      end
   end

   // ==========================================================
   // Bit buffer. Sampling at 20 MHz cannot follow a 25 MHz shift clock; the
   // controller must keep each clock phase at least three system cycles long.
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_data;
   logic fifo_rd_ready;

   assign fifo_rd_ready = !shift_stall_in;

   lsd_fifo #(
      .WIDTH (LSD_FIFO_WIDTH),
      .DEPTH (LSD_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_in   (sys_clk_in),
      .rst_n_in     (rst_n_in),
      .wr_valid_in  (sclk_rise),
      .wr_data_in   (filt_reg.serial),
      .wr_ready_out (fifo_wr_ready),
      .rd_valid_out (fifo_rd_valid),
      .rd_data_out  (fifo_rd_data),
      .rd_ready_in  (fifo_rd_ready)
   );

   // ==========================================================
   // Shift register: one stage per channel, new bits enter at stage zero.
   logic [LSD_CHANNELS-1:0] shift_reg;
   logic [LSD_CHANNELS-1:0] shift_next;
   logic                    shift_take;

   always_comb begin
      shift_take = fifo_rd_valid && fifo_rd_ready;
      shift_next = shift_reg;
      if (shift_take) begin
         shift_next = {shift_reg[LSD_LAST_STAGE-1:0], fifo_rd_data}; // R1 R2
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         shift_reg <= LSD_REG_RST;
      end else begin
         shift_reg <= shift_next;
      end
   end

   // ==========================================================
   // Channel latch.
   logic [LSD_CHANNELS-1:0] latch_reg;
   logic [LSD_CHANNELS-1:0] latch_next;

   always_comb begin
      latch_next = latch_reg;
      // Transparency at system-clock resolution keeps the outputs registered.
      if (filt_reg.strobe) begin
         latch_next = shift_next; // R3
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         latch_reg <= LSD_REG_RST;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // ==========================================================
   // Channel drive.
   logic [LSD_CHANNELS-1:0] chan_reg;
   logic [LSD_CHANNELS-1:0] chan_next;

   always_comb begin
      chan_next = filt_reg.blank ? LSD_CHAN_OFF : latch_next; // R4
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         chan_reg <= LSD_CHAN_OFF;
      end else begin
         chan_reg <= chan_next;
      end
   end

   // ==========================================================
   // Cascade output.
   logic cascade_reg;
   logic cascade_next;

   always_comb begin
      cascade_next = shift_next[LSD_LAST_STAGE]; // R5
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cascade_reg <= 1'h0;
      end else begin
         cascade_reg <= cascade_next;
      end
   end

   // ==========================================================
   // Buffer space flag.
   logic ready_reg;
   logic ready_next;

   always_comb begin
      ready_next = fifo_wr_ready;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ready_reg <= 1'h0;
      end else begin
         ready_reg <= ready_next;
      end
   end

   // ==========================================================
   // Outputs come straight from the registers above.
   assign led_sink_channels_out = chan_reg;
   assign cascade_data_out      = cascade_reg;
   assign accept_ready_out      = ready_reg;

endmodule
`default_nettype wire

// >>> core/lsd_fifo.sv
// Small valid/ready FIFO placed between pin sampling and the shift register.
`timescale 1ns/10ps
`default_nettype none
module lsd_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   // Fill side
   input  wire logic             wr_valid_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  wr_ready_out,
   // Drain side
   output logic                  rd_valid_out,
   output logic [WIDTH-1:0]      rd_data_out,
   input  wire logic             rd_ready_in
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_COUNT  = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [AW-1:0] PTR_ONE  = AW'(1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    wr_ptr_next;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    rd_ptr_next;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   assign wr_ready_out = (count_reg != FULL_COUNT);
   assign rd_valid_out = (count_reg != '0);
   assign rd_data_out  = mem_reg[rd_ptr_reg];

   // ==========================================================
   // Pointer and occupancy
   always_comb begin
      push        = wr_valid_in && wr_ready_out;
      pop         = rd_valid_out && rd_ready_in;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_ONE;
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_ONE;
      end
      if (push && !pop) begin
         count_next = count_reg + ONE_COUNT;
      end else if (pop && !push) begin
         count_next = count_reg - ONE_COUNT;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
      end
   end

   // Storage needs no reset; an entry is never read before it is written.
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= wr_data_in;
      end
   end

endmodule
`default_nettype wire

// >>> core/lsd_pkg.sv
// Shared constants and carrier types for the LED sink shift/latch block.
package lsd_pkg;

   // ==========================================================
   // Widths and sizes
   localparam int unsigned LSD_CHANNELS   = 16;
   localparam int unsigned LSD_FIFO_DEPTH = 4;
   localparam int unsigned LSD_FIFO_WIDTH = 1;

   // ==========================================================
   // Reset and drive values
   localparam logic [LSD_CHANNELS-1:0] LSD_CHAN_OFF = 16'h0000;
   localparam logic [LSD_CHANNELS-1:0] LSD_REG_RST  = 16'h0000;
   localparam logic [3:0]              LSD_PIN_RST  = 4'h0;
   localparam int unsigned             LSD_LAST_STAGE = LSD_CHANNELS - 1;

   // ==========================================================
   // Timing: system clock and fastest shift clock the controller may use.
   localparam int unsigned LSD_SYS_CLK_HZ     = 20_000_000;
   localparam int unsigned LSD_SHIFT_CLK_MAX_MHZ = 25;

   // ==========================================================
   // Pin group sampled from outside the clock domain.
   typedef struct packed {
      logic serial;
      logic shift_clk;
      logic strobe;
      logic blank;
   } lsd_pins_t;

endpackage

// >>> dv/lsd_chk_sva.sv
// Port-level assertions for the LED sink shift and latch block.
`timescale 1ns/10ps
`default_nettype none
module lsd_chk
   import lsd_pkg::*;
(
   input wire logic                    sys_clk_in,
   input wire logic                    rst_n_in,
   input wire logic                    serial_data_in,
   input wire logic                    shift_clk_in,
   input wire logic                    latch_strobe_in,
   input wire logic                    output_enable_n_in,
   input wire logic                    shift_stall_in,
   input wire logic [LSD_CHANNELS-1:0] led_sink_channels_out,
   input wire logic                    cascade_data_out,
   input wire logic                    accept_ready_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Windows are long enough to cover the pin synchronisers and the FIFO hop.
   logic       run;
   logic       sclk_q;
   logic [3:0] since_rise;
   logic [3:0] run_len;
   assign run = latch_strobe_in && !output_enable_n_in && !shift_stall_in;
   // Counters stand in for long repetitions: cycles since the last raw shift
   // clock rise, and length of the current run of passing, unblanked, unstalled cycles.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sclk_q     <= 1'h0;
         since_rise <= 4'hF;
         run_len    <= 4'h0;
      end else begin
         sclk_q <= shift_clk_in;
         if (shift_clk_in && !sclk_q) begin
            since_rise <= 4'h0;
         end else if (since_rise != 4'hF) begin
            since_rise <= since_rise + 4'h1;
         end
         if (!run) begin
            run_len <= 4'h0;
         end else if (run_len != 4'hF) begin
            run_len <= run_len + 4'h1;
         end
      end
   end
   a_blank_all_off: assert property (output_enable_n_in[*6] |->
      led_sink_channels_out == LSD_CHAN_OFF) else $error("channels on while blanked");
   a_hold_latch: assert property ((!latch_strobe_in && !output_enable_n_in)[*8] |=>
      $stable(led_sink_channels_out)) else $error("latch changed while held");
   a_cascade_last: assert property (run[*8] |->
      cascade_data_out == led_sink_channels_out[LSD_LAST_STAGE]) else $error("cascade bad");
   a_fall_quiet: assert property ((!shift_clk_in && !shift_stall_in)[*8] |->
      $stable(cascade_data_out)) else $error("cascade moved without rise");
   a_shift_advance: assert property ((since_rise == 4'h8) && (run_len >= 4'h9) && run |->
      led_sink_channels_out[15:1] == $past(led_sink_channels_out[14:0], 10))
      else $error("register did not advance");
   a_ready_flows: assert property ((!shift_stall_in)[*8] |-> accept_ready_out)
      else $error("buffer full without stall");
   cover property (output_enable_n_in[*6]);
   cover property (!accept_ready_out);
   cover property ($rose(cascade_data_out));
endmodule
bind lsd_core lsd_chk i_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .serial_data_in(serial_data_in), .shift_clk_in(shift_clk_in),
   .latch_strobe_in(latch_strobe_in), .output_enable_n_in(output_enable_n_in),
   .shift_stall_in(shift_stall_in), .led_sink_channels_out(led_sink_channels_out),
   .cascade_data_out(cascade_data_out), .accept_ready_out(accept_ready_out));
`default_nettype wire

// >>> dv/lsd_ctrl.sv
// Display controller model that drives the serial shift pins.
`timescale 1ns/10ps
`default_nettype none
module lsd_ctrl (
   input  wire logic sys_clk_in,
   output logic      serial_out,
   output logic      shift_clk_out,
   output logic      strobe_out,
   output logic      enable_n_out
);
   initial begin
      serial_out = 1'b0;
      shift_clk_out = 1'b0;
      strobe_out = 1'b0;
      enable_n_out = 1'b0;
   end
   task automatic pins(input logic stb, input logic blk);
      @(posedge sys_clk_in);
      strobe_out <= stb;
      enable_n_out <= blk;
   endtask
   // Five cycles low and six high give about 1.8 MHz, well under the ceiling, and data held both sides.
   task automatic send(input logic [15:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge sys_clk_in);
         serial_out <= w[i];
         shift_clk_out <= 1'b0;
         repeat (5) @(posedge sys_clk_in);
         shift_clk_out <= 1'b1;
         repeat (5) @(posedge sys_clk_in);
      end
      @(posedge sys_clk_in);
      shift_clk_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> dv/test_led_sink_shift_latch.sv
// Self-checking testbench for the LED sink shift and latch block.
`timescale 1ns/10ps
`default_nettype none
module test_led_sink_shift_latch;
   import lsd_pkg::*;
   logic        sys_clk_in, rst_n_in, stall, ser, sclk, stb, blk, casc, rdy;
   logic [15:0] chan;
   int          fail_count, num_checks, cyc;
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   lsd_ctrl i_ctrl (.sys_clk_in(sys_clk_in), .serial_out(ser), .shift_clk_out(sclk),
      .strobe_out(stb), .enable_n_out(blk));
   lsd_core i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .serial_data_in(ser),
      .shift_clk_in(sclk), .latch_strobe_in(stb), .output_enable_n_in(blk),
      .shift_stall_in(stall), .led_sink_channels_out(chan), .cascade_data_out(casc),
      .accept_ready_out(rdy));
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_load;
      i_ctrl.pins(1'b1, 1'b0);
      i_ctrl.send(16'hA5C3, 16);
      w(12);
      chk(chan, 16'hA5C3);
      chk({15'h0000, casc}, 16'h0001);
      $display("load test done");
   endtask
   task automatic t_hold;
      i_ctrl.pins(1'b0, 1'b0);
      w(8);
      i_ctrl.send(16'h0F0F, 16);
      w(12);
      chk(chan, 16'hA5C3);
      chk({15'h0000, casc}, 16'h0000);
      i_ctrl.pins(1'b1, 1'b0);
      w(10);
      chk(chan, 16'h0F0F);
      $display("hold test done");
   endtask
   task automatic t_blank;
      i_ctrl.pins(1'b1, 1'b1);
      w(10);
      chk(chan, LSD_CHAN_OFF);
      i_ctrl.pins(1'b1, 1'b0);
      w(10);
      chk(chan, 16'h0F0F);
      i_ctrl.send(16'h000F, 4);
      w(12);
      chk(chan, 16'hF0FF);
      chk({15'h0000, casc}, 16'h0001);
      $display("blank test done");
   endtask
   // Five edges while stalled: four fill the buffer, the fifth must be lost.
   task automatic t_stall;
      @(posedge sys_clk_in);
      stall <= 1'b1;
      i_ctrl.send(16'h0016, 5);
      w(2);
      chk({15'h0000, rdy}, 16'h0000);
      chk(chan, 16'hF0FF);
      @(posedge sys_clk_in);
      stall <= 1'b0;
      w(20);
      chk(chan, 16'h0FFB);
      $display("stall test done");
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      rst_n_in = 1'b0;
      stall = 1'b0;
      w(2);
      rst_n_in <= 1'b1;
      w(5);
      t_load();
      t_hold();
      t_blank();
      t_stall();
      report_and_stop();
   end
endmodule
`default_nettype wire
